// File: common/ds_gate_pkg.sv
package ds_gate_pkg;
  localparam logic [11:0] DS_GATE_OFF = 12'h120;
  localparam logic [11:0] INT_STATUS_OFF = 12'h124;
  localparam logic [11:0] INT_MASK_OFF = 12'h128;
  localparam logic [11:0] GATE_STATE_OFF = 12'h12c;
  localparam logic [31:0] SYSCTL_BASE = 32'h400fe000;
  localparam int CONV_BIT = 16;
  localparam int SPEED_LO = 8;
  localparam int HIB_BIT = 6;
  localparam int WDOG_BIT = 3;
  localparam logic [31:0] DS_GATE_RESET = 32'h00000040;
  localparam logic [31:0] DS_GATE_WMASK = 32'h00010348;
  localparam logic [1:0] SPEED_1M = 2'h3;
  localparam logic [1:0] SPEED_500K = 2'h2;
  localparam logic [1:0] SPEED_250K = 2'h1;
  localparam logic [1:0] SPEED_125K = 2'h0;
  localparam logic [3:0] INT_RESET = 4'h0;
  localparam logic [1:0] MODE_RUN = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_DEEP = 2'h2;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic conv;
    logic hibernate_gate_bit;
    logic wdog;
  } unit_gate_t;

  // Peripheral access attempts, one strobe each for converter and watchdog (none for hibernation)
  typedef struct packed {
    logic conv;
    logic wdog;
  } unit_access_t;
endpackage

// File: verilog/deep_sleep_gate.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Set gate bit clocks unit, clear disables
// - Access to gated converter or watchdog gives bus fault (hibernation has no fault path)
// - Gate bits reset unclocked unless noted
// - Register resets to 0x00000040
// - Gate bits apply only in deep sleep with auto gating; speed bits apply in every mode
// - Auto gating selects sleep-state registers
// - Bit 16 gates converter module 0
// - Bits 9:8 select converter sample rate
// - Bit 6 gates hibernation unit
// - Bit 3 gates watchdog, faults when gated
// - Reserved bits read-only, read zero
// - Decoded at offset 0x120
module deep_sleep_gate (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire ds_gate_pkg::reg_req_t bus_req,
  output logic [31:0] bus_rdata,
  input wire logic [1:0] power_mode,
  input wire logic auto_gating_select,
  input wire ds_gate_pkg::unit_gate_t run_gate,
  input wire ds_gate_pkg::unit_gate_t sleep_gate,
  input wire ds_gate_pkg::unit_access_t unit_access,
  output ds_gate_pkg::unit_gate_t unit_clk_en,
  output logic [1:0] converter_speed_field,
  output logic bus_fault,
  output logic irq
);
  import ds_gate_pkg::*;

  logic [31:0] gate_q;
  logic [3:0] int_status_q;
  logic [3:0] int_mask_q;
  logic [3:0] int_event;
  logic [3:0] status_rd_clr;
  unit_gate_t sel_gate;
  unit_gate_t deep_gate;
  unit_gate_t unit_clk_en_q;
  logic [1:0] speed_q;
  logic [31:0] rdata_q;
  logic fault_q;
  logic irq_q;
  logic fault_ev;

  // Writable bits are masked so reserved positions never store
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gate_q <= DS_GATE_RESET;
    end else if (bus_req.wr && bus_req.addr == DS_GATE_OFF) begin
      gate_q <= bus_req.wdata & DS_GATE_WMASK;
    end
  end

  assign deep_gate.conv = gate_q[CONV_BIT];
  assign deep_gate.hibernate_gate_bit = gate_q[HIB_BIT];
  assign deep_gate.wdog = gate_q[WDOG_BIT];

  // Without auto gating the run-mode set stays in force in every state
  always_comb begin
    sel_gate = run_gate;
    if (auto_gating_select) begin
      if (power_mode == MODE_DEEP) begin
        sel_gate = deep_gate;
      end else if (power_mode == MODE_SLEEP) begin
        sel_gate = sleep_gate;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      unit_clk_en_q <= '0;
      speed_q <= SPEED_125K;
    end else begin
      unit_clk_en_q <= sel_gate;
      speed_q <= gate_q[SPEED_LO +: 2];
    end
  end

  // Hibernation has no fault path while gated
  assign fault_ev = (unit_access.conv && !unit_clk_en_q.conv) ||
                    (unit_access.wdog && !unit_clk_en_q.wdog);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_ev;
    end
  end

  // Events: 0 conv fault, 1 watchdog fault, 2 gate write, 3 spare (reads zero)
  assign int_event[0] = unit_access.conv && !unit_clk_en_q.conv;
  assign int_event[1] = unit_access.wdog && !unit_clk_en_q.wdog;
  assign int_event[2] = bus_req.wr && bus_req.addr == DS_GATE_OFF;
  assign int_event[3] = 1'b0;
  assign status_rd_clr = (bus_req.rd && bus_req.addr == INT_STATUS_OFF) ? 4'hf : 4'h0;

  // Set wins over the read-clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      int_status_q <= INT_RESET;
    end else begin
      int_status_q <= (int_status_q & ~status_rd_clr) | int_event;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      int_mask_q <= INT_RESET;
    end else if (bus_req.wr && bus_req.addr == INT_MASK_OFF) begin
      int_mask_q <= bus_req.wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((int_status_q & ~status_rd_clr) | int_event) & int_mask_q);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (bus_req.rd) begin
      if (bus_req.addr == DS_GATE_OFF) begin
        rdata_q <= gate_q;
      end else if (bus_req.addr == INT_STATUS_OFF) begin
        rdata_q <= {28'h0000000, int_status_q};
      end else if (bus_req.addr == INT_MASK_OFF) begin
        rdata_q <= {28'h0000000, int_mask_q};
      end else if (bus_req.addr == GATE_STATE_OFF) begin
        rdata_q <= {29'h00000000, unit_clk_en_q};
      end else begin
        rdata_q <= '0;
      end
    end else begin
      rdata_q <= '0;
    end
  end

  assign bus_rdata = rdata_q;
  assign unit_clk_en = unit_clk_en_q;
  assign converter_speed_field = speed_q;
  assign bus_fault = fault_q;
  assign irq = irq_q;
endmodule
`default_nettype wire

// File: test/deep_sleep_gate_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dsg_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire ds_gate_pkg::reg_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic [1:0] power_mode,
  input wire logic auto_gating_select,
  input wire ds_gate_pkg::unit_gate_t run_gate,
  input wire ds_gate_pkg::unit_gate_t sleep_gate,
  input wire ds_gate_pkg::unit_access_t unit_access,
  input wire ds_gate_pkg::unit_gate_t unit_clk_en,
  input wire logic [1:0] converter_speed_field,
  input wire logic bus_fault,
  input wire logic irq
);
  import ds_gate_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_WF: assert property (unit_access.wdog && !unit_clk_en.wdog |=> bus_fault)
    else $error("no wdog fault");
  AST_CF: assert property (unit_access.conv && !unit_clk_en.conv |=> bus_fault)
    else $error("no conv fault");
  AST_NF: assert property ((unit_access & {unit_clk_en.conv, unit_clk_en.wdog}) == unit_access
    |=> !bus_fault) else $error("bad fault");
  AST_RZ: assert property (bus_req.rd && bus_req.addr == DS_GATE_OFF
    |=> (bus_rdata & ~DS_GATE_WMASK) == 0) else $error("reserved set");
  AST_SP: assert property (bus_req.wr && bus_req.addr == DS_GATE_OFF
    |-> ##2 converter_speed_field == $past(bus_req.wdata[9:8], 2)) else $error("bad speed");
  AST_RS: assert property (!auto_gating_select || power_mode == MODE_RUN
    |=> unit_clk_en == $past(run_gate)) else $error("bad run set");
  AST_SS: assert property (auto_gating_select && power_mode == MODE_SLEEP
    |=> unit_clk_en == $past(sleep_gate)) else $error("bad sleep set");
  AST_IH: assert property (irq && !bus_req.rd && !bus_req.wr
    && !$past(bus_req.rd) && !$past(bus_req.wr) |=> irq) else $error("irq lost");
  cover property (bus_fault);
  cover property (irq);
  cover property (power_mode == MODE_DEEP && unit_clk_en.conv);
endmodule
bind deep_sleep_gate dsg_chk u_chk (.*);
`default_nettype wire

// File: test/deep_sleep_gate_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CK(a,b) begin n_tests++; if ((a)!==(b)) begin miscompares++; $display("unexpected %0t bad", $time); end end
module deep_sleep_gate_tb_top;
  import ds_gate_pkg::*;
  logic sys_clk = 0;
  logic sys_rst = 1;
  reg_req_t bus_req = '0;
  logic [1:0] power_mode = MODE_DEEP;
  logic auto_gating_select = 1;
  unit_gate_t run_gate = '0;
  unit_gate_t sleep_gate = '0;
  unit_access_t unit_access = '0;
  unit_gate_t unit_clk_en;
  logic [31:0] bus_rdata;
  logic [1:0] converter_speed_field;
  logic bus_fault;
  logic irq;
  int miscompares = 0;
  int n_tests = 0;
  always #5 sys_clk = ~sys_clk;
  deep_sleep_gate u_dut (.*);
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk) bus_req <= {a, d, 2'b10};
    @(posedge sys_clk) bus_req <= '0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge sys_clk) bus_req <= {a, 32'h0, 2'b01};
    @(posedge sys_clk) bus_req <= '0;
    #1 `CK(bus_rdata, e)
  endtask
  task hit(input logic [1:0] v, input logic f);
    @(posedge sys_clk) unit_access <= v;
    @(posedge sys_clk) unit_access <= '0;
    #1 `CK(bus_fault, f)
  endtask
  task tick;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task t_regs;
    tick;
    `CK(unit_clk_en, 3'b010)
    rd(DS_GATE_OFF, DS_GATE_RESET);
    wr(DS_GATE_OFF, '1);
    rd(DS_GATE_OFF, DS_GATE_WMASK);
    for (int s = 0; s < 4; s++) begin
      wr(DS_GATE_OFF, 32'(s) << SPEED_LO);
      tick;
      `CK(converter_speed_field, 2'(s))
    end
    rd(12'h200, 32'h0);
    wr(DS_GATE_OFF, 32'h00000308);
    rd(DS_GATE_OFF, 32'h00000308);
  endtask
  task t_irq;
    wr(INT_MASK_OFF, 32'hf);
    wr(DS_GATE_OFF, 32'h0);
    rd(INT_STATUS_OFF, 32'h4);
    hit(2'b01, 1'b1);
    hit(2'b10, 1'b1);
    tick;
    `CK(irq, 1'b1)
    rd(INT_STATUS_OFF, 32'h3);
    tick;
    `CK(irq, 1'b0)
    wr(INT_MASK_OFF, 32'h0);
    hit(2'b01, 1'b1);
    tick;
    `CK(irq, 1'b0)
  endtask
  task t_sel;
    wr(DS_GATE_OFF, 32'h00010008);
    tick;
    `CK(unit_clk_en, 3'b101)
    hit(2'b01, 1'b0);
    @(posedge sys_clk) power_mode <= MODE_SLEEP;
    sleep_gate <= 3'b010;
    tick;
    `CK(unit_clk_en, 3'b010)
    @(posedge sys_clk) power_mode <= MODE_RUN;
    run_gate <= 3'b110;
    tick;
    `CK(unit_clk_en, 3'b110)
  endtask
  task wrap_up;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs;
    t_irq;
    t_sel;
    wrap_up;
  end
endmodule
`default_nettype wire
